// file: include/enclave_gate_consts.svh
// register offsets, field positions and codes of the privileged enclave op gate
`ifndef ENCLAVE_GATE_CONSTS_SVH
`define ENCLAVE_GATE_CONSTS_SVH
`define EG_OFF_CTRL      6'h00
`define EG_OFF_OPCODE    6'h04
`define EG_OFF_EAX       6'h08
`define EG_OFF_RAX_HI    6'h0c
`define EG_OFF_MAP_LO    6'h10
`define EG_OFF_MAP_HI    6'h14
`define EG_OFF_RBX_LO    6'h18
`define EG_OFF_RBX_HI    6'h1c
`define EG_OFF_DS_BASE   6'h20
`define EG_OFF_PAGE      6'h24
`define EG_OFF_GO        6'h28
`define EG_OFF_STATUS    6'h2c
`define EG_OP_BYTE0      8'h0f
`define EG_OP_BYTE1      8'h01
`define EG_OP_BYTE2      8'hcf
`define EG_MAX_LEAF      32'h0000000f
`define EG_MAP_LAST      32'h0000003e
`define EG_MAP_TOP       6'h3f
`define EG_LOCKFAIL_CODE 8'h07
`define EG_GP_CODE       8'h00
`define EG_LEAF_CREATE   8'h00
`define EG_LEAF_ADD      8'h01
`define EG_LEAF_INIT     8'h02
`define EG_LEAF_REMOVE   8'h03
`define EG_LEAF_EXTEND   8'h06
`define EG_LEAF_RELOAD_B 8'h07
`define EG_LEAF_RELOAD_U 8'h08
`define EG_LEAF_BLOCK    8'h09
`define EG_LEAF_TRACK    8'h0c
`define EG_CTRL_RESET    32'h00000000
`endif

// file: include/enclave_gate_pkg.sv
// types of the privileged enclave op gate
package enclave_gate_pkg;
    typedef enum logic [3:0] {
        OUT_NONE     = 4'h0,
        OUT_TX_ABORT = 4'h1,
        OUT_INV_OP   = 4'h2,
        OUT_VM_EXIT  = 4'h3,
        OUT_GP       = 4'h4,
        OUT_CONC_EXC = 4'h5,
        OUT_CONC_ERR = 4'h6,
        OUT_DISPATCH = 4'h7
    } outcome_t;

    typedef enum logic [1:0] {
        CL_Y = 2'h0,
        CL_N = 2'h1,
        CL_C = 2'h2,
        CL_U = 2'h3
    } conc_class_t;

    typedef enum logic [0:0] {
        FSM_IDLE = 1'h0,
        FSM_EVAL = 1'h1
    } fsm_t;

    // processor context bits held in the control register
    typedef struct packed {
        logic [15:0] unused;
        logic        transaction_active;
        logic        privileged_op_exit_enable;
        logic        guest_mode;
        logic        ds_expand_down;
        logic        cs_default_size;
        logic        cs_long;
        logic        long_mode_active;
        logic        paging_enable_bit;
        logic        enclave_enable_bit;
        logic        feature_lock_bit;
        logic        enclave_capability_bit;
        logic [1:0]  current_privilege_level;
        logic        system_management_state;
        logic        virtual_8086_flag;
        logic        protection_enable_bit;
    } ctrl_t;

    // opcode bytes plus prefix flags
    typedef struct packed {
        logic        pfx_rex;
        logic        pfx_addr_size;
        logic        pfx_segment;
        logic        pfx_vex;
        logic        pfx_rep;
        logic        pfx_op_size;
        logic        pfx_lock;
        logic        unused;
        logic [23:0] op_bytes;
    } opword_t;

    typedef struct packed {
        fsm_t        fsm;
        ctrl_t       ctrl;
        opword_t     opw;
        logic [31:0] eax;
        logic [31:0] rax_hi;
        logic [63:0] exit_map;
        logic [63:0] rbx;
        logic [31:0] ds_base;
        logic [31:0] page;
        outcome_t    outcome;
        logic [7:0]  leaf;
        logic [7:0]  err;
        logic        in64;
        logic [2:0]  reg_use;
        logic [63:0] lin_addr;
        logic        dispatch;
        logic        ack;
        logic [31:0] rdata;
    } state_t;
endpackage

// file: verilog/privileged_enclave_op_gate.sv
// fault check and leaf dispatch gate for the privileged enclave operation
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`include "enclave_gate_consts.svh"

// What this block does
// - recognise opcode 0f 01 cf as the privileged op, valid in 64 and 32-bit modes
// - leaf index comes from eax; upper half of rax ignored in 64-bit mode
// - invalid opcode fault when protection off, virtual-8086 set or system management
// - invalid opcode fault when privilege level above zero
// - invalid opcode fault when enclave capability bit reads zero
// - invalid opcode fault on lock, operand-size, repeat or vector prefix
// - guest exit via exit map bit at eax index, bit 63 above 62
// - protection fault code 0 when feature lock or enclave enable is zero
// - protection fault code 0 for an unsupported leaf number
// - protection fault code 0 when paging is disabled
// - protection fault code 0 for expand-down data segment outside 64-bit mode
// - active memory transaction diverts to abort handling before any other check
// - 64-bit width only when long mode active and code segment long bit set
// - linear address adds data segment base outside 64-bit mode, rbx alone in 64-bit; default-size bit has no effect
// - segment, address-size and rex prefixes are ignored
// - all checks passed means hand control to the selected leaf flow
// - rbx, rcx, rdx are leaf specific inputs, outputs or unused
// - concurrency restrictions apply when two processors touch the same protected page
// - leaf pairs classed concurrent proceed together
// - conditional pairs may end the row leaf with an error code
// - user error pairs both complete with no restriction
// - a disallowed concurrent operation raises an exception
module privileged_enclave_op_gate (
    // clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    // avalon-mm slave
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // leaf running on the other logical processor
    input  wire logic        i_peer_active,
    input  wire logic [7:0]  i_peer_leaf,
    input  wire logic [31:0] i_peer_page,
    // outcome of the last check
    output logic             o_dispatch,
    output logic      [3:0]  o_outcome,
    output logic      [7:0]  o_leaf,
    output logic      [7:0]  o_err_code,
    output logic             o_in64,
    output logic      [2:0]  o_reg_use,
    output logic      [63:0] o_lin_addr
);

    enclave_gate_pkg::state_t st_r;
    enclave_gate_pkg::state_t st_nxt;
    logic                     eval_now;
    logic                     ud_hit;
    logic                     exit_hit;
    logic                     map_bit;

    // merge a bus write into a register word under byte enables
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                res[b*8 +: 8] = wd[b*8 +: 8];
        end
        return res;
    endfunction

    // class of a row leaf against a column leaf on the same page
    function automatic enclave_gate_pkg::conc_class_t conc_class(
        input logic [7:0] row,
        input logic [7:0] col
    );
        logic a_grp;
        logic b_grp;
        a_grp = (row == `EG_LEAF_ADD) || (row == `EG_LEAF_EXTEND)
             || (row == `EG_LEAF_INIT);
        b_grp = (col == `EG_LEAF_ADD) || (col == `EG_LEAF_EXTEND)
             || (col == `EG_LEAF_INIT);
        if ((row == `EG_LEAF_TRACK) && (col == `EG_LEAF_TRACK))
            return enclave_gate_pkg::CL_N;
        else if ((row == col) && ((row == `EG_LEAF_CREATE) || (row == `EG_LEAF_ADD)
                 || (row == `EG_LEAF_REMOVE)))
            return enclave_gate_pkg::CL_N;
        else if (a_grp && b_grp)
            return enclave_gate_pkg::CL_N;
        else if ((row == `EG_LEAF_RELOAD_B) || (row == `EG_LEAF_RELOAD_U) || (row == `EG_LEAF_BLOCK))
            return enclave_gate_pkg::CL_C; // reloads pass only on distinct pages
        else
            return enclave_gate_pkg::CL_U;
    endfunction

    // which of rbx, rcx, rdx the leaf uses: bit 0 rbx, bit 1 rcx, bit 2 rdx
    function automatic logic [2:0] reg_usage(input logic [7:0] leaf);
        case (leaf)
            8'h03, 8'h09, 8'h0c:               return 3'h2; // page operand in rcx only
            8'h02, 8'h07, 8'h08, 8'h0b, 8'h0d: return 3'h7;
            default:                           return 3'h3;
        endcase
    endfunction

    assign eval_now = (st_r.fsm == enclave_gate_pkg::FSM_EVAL) && i_ce;

    // invalid opcode conditions, in check order after the abort check
    always_comb
    begin
        ud_hit = (st_r.opw.op_bytes != {`EG_OP_BYTE0, `EG_OP_BYTE1, `EG_OP_BYTE2})
              || !st_r.ctrl.protection_enable_bit || st_r.ctrl.virtual_8086_flag
              || st_r.ctrl.system_management_state
              || (st_r.ctrl.current_privilege_level != 2'h0)
              || !st_r.ctrl.enclave_capability_bit
              || st_r.opw.pfx_lock || st_r.opw.pfx_op_size
              || st_r.opw.pfx_rep || st_r.opw.pfx_vex;
        map_bit = (st_r.eax > `EG_MAP_LAST) ? st_r.exit_map[`EG_MAP_TOP]
                : st_r.exit_map[st_r.eax[5:0]];
        exit_hit = st_r.ctrl.guest_mode && st_r.ctrl.privileged_op_exit_enable
                && map_bit;
    end

    // next state: bus slave, check sequence and dispatch
    always_comb
    begin
        logic                          is64;
        logic [7:0]                    lf;
        enclave_gate_pkg::conc_class_t cls;
        st_nxt = st_r;
        st_nxt.dispatch = 1'b0;
        st_nxt.ack = 1'b0;
        is64 = st_r.ctrl.long_mode_active && st_r.ctrl.cs_long;
        lf = st_r.eax[7:0];
        cls = conc_class(lf, i_peer_leaf);
        if ((i_avs_read || i_avs_write) && !st_r.ack)
        begin
            st_nxt.ack = 1'b1;
            if (i_avs_write)
            begin
                case (i_avs_address & 6'h3c)
                    `EG_OFF_CTRL:    st_nxt.ctrl = merge(st_r.ctrl, i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_OPCODE:  st_nxt.opw = merge(st_r.opw, i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_EAX:     st_nxt.eax = merge(st_r.eax, i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_RAX_HI:  st_nxt.rax_hi = merge(st_r.rax_hi, i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_MAP_LO:  st_nxt.exit_map[31:0] =
                        merge(st_r.exit_map[31:0], i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_MAP_HI:  st_nxt.exit_map[63:32] =
                        merge(st_r.exit_map[63:32], i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_RBX_LO:  st_nxt.rbx[31:0] = merge(st_r.rbx[31:0], i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_RBX_HI:  st_nxt.rbx[63:32] = merge(st_r.rbx[63:32], i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_DS_BASE: st_nxt.ds_base = merge(st_r.ds_base, i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_PAGE:    st_nxt.page = merge(st_r.page, i_avs_writedata, i_avs_byteenable);
                    `EG_OFF_GO:      st_nxt.fsm = enclave_gate_pkg::FSM_EVAL;
                    default:         st_nxt.fsm = st_r.fsm; // unmapped writes are dropped
                endcase
            end
            else
            begin
                case (i_avs_address & 6'h3c)
                    `EG_OFF_CTRL:    st_nxt.rdata = st_r.ctrl;
                    `EG_OFF_OPCODE:  st_nxt.rdata = st_r.opw;
                    `EG_OFF_EAX:     st_nxt.rdata = st_r.eax;
                    `EG_OFF_RAX_HI:  st_nxt.rdata = st_r.rax_hi;
                    `EG_OFF_MAP_LO:  st_nxt.rdata = st_r.exit_map[31:0];
                    `EG_OFF_MAP_HI:  st_nxt.rdata = st_r.exit_map[63:32];
                    `EG_OFF_RBX_LO:  st_nxt.rdata = st_r.rbx[31:0];
                    `EG_OFF_RBX_HI:  st_nxt.rdata = st_r.rbx[63:32];
                    `EG_OFF_DS_BASE: st_nxt.rdata = st_r.ds_base;
                    `EG_OFF_PAGE:    st_nxt.rdata = st_r.page;
                    `EG_OFF_STATUS:  st_nxt.rdata = {8'h00, st_r.err, st_r.leaf,
                        st_r.reg_use, st_r.in64, st_r.outcome};
                    default:         st_nxt.rdata = 32'h00000000;
                endcase
            end
        end
        // one evaluation cycle; the first failing check alone is reported
        case (st_r.fsm)
            enclave_gate_pkg::FSM_EVAL:
            begin
                st_nxt.fsm = enclave_gate_pkg::FSM_IDLE;
                st_nxt.leaf = lf;
                st_nxt.err = `EG_GP_CODE;
                st_nxt.in64 = is64;
                st_nxt.reg_use = reg_usage(lf);
                // segment, address-size, rex prefixes and cs default size never looked at
                st_nxt.lin_addr = is64 ? st_r.rbx
                                : {32'h00000000, st_r.rbx[31:0] + st_r.ds_base};
                if (st_r.ctrl.transaction_active)
                    st_nxt.outcome = enclave_gate_pkg::OUT_TX_ABORT;
                else if (ud_hit)
                    st_nxt.outcome = enclave_gate_pkg::OUT_INV_OP;
                else if (exit_hit)
                    st_nxt.outcome = enclave_gate_pkg::OUT_VM_EXIT;
                else if (!st_r.ctrl.feature_lock_bit || !st_r.ctrl.enclave_enable_bit)
                    st_nxt.outcome = enclave_gate_pkg::OUT_GP;
                else if (st_r.eax > `EG_MAX_LEAF)
                    st_nxt.outcome = enclave_gate_pkg::OUT_GP;
                else if (!st_r.ctrl.paging_enable_bit)
                    st_nxt.outcome = enclave_gate_pkg::OUT_GP;
                else if (!is64 && st_r.ctrl.ds_expand_down)
                    st_nxt.outcome = enclave_gate_pkg::OUT_GP;
                else if (i_peer_active && (i_peer_page == st_r.page)
                         && (cls == enclave_gate_pkg::CL_N))
                    st_nxt.outcome = enclave_gate_pkg::OUT_CONC_EXC;
                else if (i_peer_active && (i_peer_page == st_r.page)
                         && (cls == enclave_gate_pkg::CL_C))
                begin
                    st_nxt.outcome = enclave_gate_pkg::OUT_CONC_ERR;
                    st_nxt.err = `EG_LOCKFAIL_CODE;
                end
                else
                begin
                    st_nxt.outcome = enclave_gate_pkg::OUT_DISPATCH;
                    st_nxt.dispatch = 1'b1;
                end
            end
            default:
                st_nxt.outcome = st_r.outcome;
        endcase
    end

    // state register; synchronous reset, otherwise frozen while the clock enable is low
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            st_r <= '0;
            st_r.ctrl <= `EG_CTRL_RESET;
        end
        else if (i_ce)
            st_r <= st_nxt;
    end

    // outputs
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_r.ack;
    assign o_avs_readdata = st_r.rdata;
    assign o_dispatch = st_r.dispatch;
    assign o_outcome = st_r.outcome;
    assign o_leaf = st_r.leaf;
    assign o_err_code = st_r.err;
    assign o_in64 = st_r.in64;
    assign o_reg_use = st_r.reg_use;
    assign o_lin_addr = st_r.lin_addr;

    // checks on the gate
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_eval_clean;
        eval_now && !st_r.ctrl.transaction_active && !ud_hit;
    endsequence

    sequence s_past_exit;
        s_eval_clean ##0 !exit_hit;
    endsequence

    property p_tx_first;
        eval_now && st_r.ctrl.transaction_active
            |=> o_outcome == enclave_gate_pkg::OUT_TX_ABORT;
    endproperty
    a_tx_first: assert property (p_tx_first) else $error("abort not reported first");

    property p_ud_mode;
        eval_now && !st_r.ctrl.transaction_active && (!st_r.ctrl.protection_enable_bit
            || st_r.ctrl.virtual_8086_flag || st_r.ctrl.system_management_state)
            |=> o_outcome == enclave_gate_pkg::OUT_INV_OP;
    endproperty
    a_ud_mode: assert property (p_ud_mode) else $error("mode fault missing");

    property p_ud_cpl;
        eval_now && !st_r.ctrl.transaction_active && (st_r.ctrl.current_privilege_level != 2'h0)
            |=> o_outcome == enclave_gate_pkg::OUT_INV_OP && !o_dispatch;
    endproperty
    a_ud_cpl: assert property (p_ud_cpl) else $error("privilege fault missing");

    property p_ud_cap;
        eval_now && !st_r.ctrl.transaction_active && !st_r.ctrl.enclave_capability_bit
            |=> o_outcome == enclave_gate_pkg::OUT_INV_OP;
    endproperty
    a_ud_cap: assert property (p_ud_cap) else $error("capability fault missing");

    property p_exit;
        s_eval_clean ##0 (st_r.ctrl.guest_mode && st_r.ctrl.privileged_op_exit_enable
            && (st_r.eax > 32'h3e) && st_r.exit_map[63]) |=> o_outcome == enclave_gate_pkg::OUT_VM_EXIT;
    endproperty
    a_exit: assert property (p_exit) else $error("exit via top map bit missing");

    property p_gp_feat;
        s_past_exit ##0 (!st_r.ctrl.feature_lock_bit || !st_r.ctrl.enclave_enable_bit)
            |=> o_outcome == enclave_gate_pkg::OUT_GP && o_err_code == 8'h00;
    endproperty
    a_gp_feat: assert property (p_gp_feat) else $error("feature fault missing");

    property p_gp_pg;
        s_past_exit ##0 !st_r.ctrl.paging_enable_bit
            |=> o_outcome == enclave_gate_pkg::OUT_GP;
    endproperty
    a_gp_pg: assert property (p_gp_pg) else $error("paging fault missing");

    property p_dispatch;
        o_dispatch |-> o_outcome == enclave_gate_pkg::OUT_DISPATCH && o_leaf <= 8'h0f
            && $past(eval_now);
    endproperty
    a_dispatch: assert property (p_dispatch) else $error("dispatch without passing checks");

    property p_bus;
        i_ce && i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest || !i_ce;
    endproperty
    a_bus: assert property (p_bus) else $error("read answer late");

    property p_ud_pfx;
        eval_now && !st_r.ctrl.transaction_active && (st_r.opw.pfx_lock || st_r.opw.pfx_op_size
            || st_r.opw.pfx_rep || st_r.opw.pfx_vex) |=> o_outcome == enclave_gate_pkg::OUT_INV_OP;
    endproperty
    a_ud_pfx: assert property (p_ud_pfx) else $error("prefix not refused");

    property p_gp_leaf;
        s_past_exit ##0 st_r.ctrl.feature_lock_bit && st_r.ctrl.enclave_enable_bit
            && (st_r.eax > 32'h0000000f) |=> o_outcome == enclave_gate_pkg::OUT_GP;
    endproperty
    a_gp_leaf: assert property (p_gp_leaf) else $error("bad leaf not refused");

    property p_gp_ds;
        s_past_exit ##0 st_r.ctrl.ds_expand_down && !st_r.ctrl.cs_long
            |=> o_outcome == enclave_gate_pkg::OUT_GP;
    endproperty
    a_gp_ds: assert property (p_gp_ds) else $error("expand-down not refused");

    property p_lin32;
        eval_now && !(st_r.ctrl.long_mode_active && st_r.ctrl.cs_long)
            |=> !o_in64 && o_lin_addr[63:32] == 32'h00000000;
    endproperty
    a_lin32: assert property (p_lin32) else $error("wide address in 32-bit mode");

endmodule // privileged_enclave_op_gate

// file: verif/peer_lp_model.sv
// model of the other logical processor running enclave leaves
module peer_lp_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // leaf that the peer software runs
    input  wire logic        i_run,
    input  wire logic [7:0]  i_leaf,
    input  wire logic [31:0] i_page,
    // what the gate sees of the peer
    output logic             o_active,
    output logic      [7:0]  o_leaf,
    output logic      [31:0] o_page
);
    logic [7:0]  leaf_r;
    logic [31:0] page_r;

    // a single slot: one leaf at a time, so the peer never overlaps itself
    always_ff @(posedge i_clk)
    begin
        o_active <= i_rstn & i_run;
        if (!i_rstn)
        begin
            leaf_r <= 8'h00;
            page_r <= 32'h00000000;
        end
        else if (i_run)
        begin
            leaf_r <= i_leaf;
            page_r <= i_page;
        end
    end

    // released lines show the inverse of the last value, never a stale match
    assign o_leaf = o_active ? leaf_r : ~leaf_r;
    assign o_page = o_active ? page_r : ~page_r;
endmodule // peer_lp_model

// file: verif/test_privileged_enclave_op_gate.sv
// self-checking bench of the privileged enclave op gate
`include "enclave_gate_consts.svh"
module test_privileged_enclave_op_gate;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] C32 = 32'h000001e1;
    localparam logic [31:0] C64 = 32'h000007e1;
    localparam logic [31:0] OPC = {8'h00, `EG_OP_BYTE0, `EG_OP_BYTE1, `EG_OP_BYTE2};
    localparam logic [3:0]  TXA = enclave_gate_pkg::OUT_TX_ABORT;
    localparam logic [3:0]  UD  = enclave_gate_pkg::OUT_INV_OP;
    localparam logic [3:0]  VMX = enclave_gate_pkg::OUT_VM_EXIT;
    localparam logic [3:0]  GP  = enclave_gate_pkg::OUT_GP;
    localparam logic [3:0]  CNX = enclave_gate_pkg::OUT_CONC_EXC;
    localparam logic [3:0]  CER = enclave_gate_pkg::OUT_CONC_ERR;
    localparam logic [3:0]  DSP = enclave_gate_pkg::OUT_DISPATCH;
    logic        clk, rstn, rd, wr, prun, p_act, o_dispatch, o_in64, waitreq;
    logic [5:0]  addr;
    logic [7:0]  pleaf, p_leaf, o_leaf, o_err_code;
    logic [31:0] wdata, ppage, p_page, rdata, q;
    logic [3:0]  o_outcome;
    logic [2:0]  o_reg_use;
    logic [63:0] o_lin_addr;
    int          n_errors = 0;
    int          total_checks = 0;

    // device under test and the peer processor
    privileged_enclave_op_gate dut (.i_clk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_peer_active(p_act),
        .i_peer_leaf(p_leaf), .i_peer_page(p_page), .o_dispatch(o_dispatch), .o_outcome(o_outcome),
        .o_leaf(o_leaf), .o_err_code(o_err_code), .o_in64(o_in64), .o_reg_use(o_reg_use),
        .o_lin_addr(o_lin_addr));
    peer_lp_model peer (.i_clk(clk), .i_rstn(rstn), .i_run(prun), .i_leaf(pleaf), .i_page(ppage),
        .o_active(p_act), .o_leaf(p_leaf), .o_page(p_page));

    // 125 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // verdict and end of run
    task automatic final_report;
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // compare one value
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon access, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= ~w;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 40);
        if (waitreq !== 1'b0)
        begin
            n_errors++;
            final_report();
        end
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    // load context, start a check, judge results and the dispatch pulse
    task automatic run_case(input logic [31:0] ctl, input logic [31:0] op, input logic [31:0] eax,
                            input logic [63:0] map, input logic [3:0] exp, input logic [7:0] err);
        wreg(`EG_OFF_CTRL, ctl);
        wreg(`EG_OFF_OPCODE, op);
        wreg(`EG_OFF_EAX, eax);
        wreg(`EG_OFF_MAP_LO, map[31:0]);
        wreg(`EG_OFF_MAP_HI, map[63:32]);
        wreg(`EG_OFF_GO, 32'h1);
        @(negedge clk);
        chk(64'(o_outcome), 64'(exp));
        chk(64'(o_err_code), 64'(err));
        chk(64'(o_leaf), 64'(eax[7:0]));
        chk(64'(o_dispatch), 64'(exp == DSP));
        @(negedge clk);
        chk(64'(o_dispatch), 64'h0);
    endtask

    // reset values, unmapped and write-only places
    task automatic test_regs;
        @(negedge clk);
        chk(64'(o_outcome), 64'h0);
        chk(o_lin_addr, 64'h0);
        wreg(`EG_OFF_STATUS, 32'hffffffff);
        bus(1'b0, `EG_OFF_STATUS, 32'h0, q);
        chk(64'(q), 64'h0);
        bus(1'b0, 6'h30, 32'h0, q);
        chk(64'(q), 64'h0);
        bus(1'b0, `EG_OFF_GO, 32'h0, q);
        chk(64'(q), 64'h0);
    endtask

    // fault checks and their order
    task automatic test_faults;
        run_case(C64, OPC, 32'hc, 64'h0, DSP, 8'h0);
        run_case(C32, OPC, 32'hc, 64'h0, DSP, 8'h0);
        run_case(32'h87e0, OPC | 32'h02000000, 32'h10, 64'h0, TXA, 8'h0);
        run_case(C64 & ~32'h1, OPC, 32'hc, 64'h0, UD, 8'h0);
        run_case(C64 | 32'h2, OPC, 32'hc, 64'h0, UD, 8'h0);
        run_case(C64 | 32'h4, OPC, 32'hc, 64'h0, UD, 8'h0);
        run_case(C64 | 32'h8, OPC, 32'hc, 64'h0, UD, 8'h0);
        run_case(C64 | 32'h18, OPC, 32'hc, 64'h0, UD, 8'h0);
        run_case(C64 & ~32'h20, OPC, 32'hc, 64'h0, UD, 8'h0);
        for (int b = 25; b < 29; b++)
            run_case(C64, OPC | (32'h1 << b), 32'hc, 64'h0, UD, 8'h0);
        run_case(C64, OPC | 32'he0000000, 32'hc, 64'h0, DSP, 8'h0);
        run_case(C64, 32'h000f01d7, 32'hc, 64'h0, UD, 8'h0);
        run_case(C64 & ~32'h40, OPC, 32'hc, 64'h0, GP, 8'h0);
        run_case(C64 & ~32'h80, OPC, 32'hc, 64'h0, GP, 8'h0);
        run_case(C64, OPC, 32'h10, 64'h0, GP, 8'h0);
        run_case(C64, OPC, 32'hf, 64'h0, DSP, 8'h0);
        run_case(C64 & ~32'h100, OPC, 32'hc, 64'h0, GP, 8'h0);
        run_case(C32 | 32'h1000, OPC, 32'hc, 64'h0, GP, 8'h0);
        run_case(C64 | 32'h1000, OPC, 32'hc, 64'h0, DSP, 8'h0);
    endtask

    // guest exits through the exit map
    task automatic test_exit;
        run_case(C64 | 32'h6000, OPC, 32'h5, 64'h20, VMX, 8'h0);
        run_case(C64 | 32'h6000, OPC, 32'h6, 64'h20, DSP, 8'h0);
        run_case(C64 | 32'h6000, OPC, 32'h3e, 64'h4000000000000000, VMX, 8'h0);
        run_case(C64 | 32'h6000, OPC, 32'h3e, 64'h8000000000000000, GP, 8'h0);
        run_case(C64 | 32'h6000, OPC, 32'h40, 64'h8000000000000000, VMX, 8'h0);
        run_case(C64 | 32'h2000, OPC, 32'h5, 64'hffffffffffffffff, DSP, 8'h0);
        run_case(32'h67a1, OPC, 32'h5, 64'h20, VMX, 8'h0);
        run_case(C64 | 32'h6008, OPC, 32'h5, 64'h20, UD, 8'h0);
    endtask

    // operand width and linear address forming
    task automatic test_addr;
        wreg(`EG_OFF_RBX_LO, 32'hfffffff0);
        wreg(`EG_OFF_RBX_HI, 32'h12345678);
        wreg(`EG_OFF_DS_BASE, 32'h20);
        wreg(`EG_OFF_RAX_HI, 32'hffffffff);
        run_case(C32 | 32'h800, OPC, 32'hc, 64'h0, DSP, 8'h0);
        chk(o_lin_addr, 64'h10);
        run_case(C32 | 32'h400, OPC, 32'hc, 64'h0, DSP, 8'h0);
        chk(64'(o_in64), 64'h0);
        run_case(C32 | 32'h200, OPC, 32'hc, 64'h0, DSP, 8'h0);
        chk(64'(o_in64), 64'h0);
        run_case(C64, OPC, 32'hc, 64'h0, DSP, 8'h0);
        chk(o_lin_addr, 64'h12345678fffffff0);
        chk(64'(o_reg_use), 64'h2);
        bus(1'b0, `EG_OFF_STATUS, 32'h0, q);
        chk(64'(q), 64'h00000c57);
    endtask

    // start a leaf on the peer processor
    task automatic peer_go(input logic [7:0] l, input logic [31:0] p);
        @(posedge clk);
        prun  <= 1'b1;
        pleaf <= l;
        ppage <= p;
    endtask

    // two processors on the same or different protected pages
    task automatic test_conc;
        wreg(`EG_OFF_PAGE, 32'h1000);
        peer_go(8'h0c, 32'h1000);
        run_case(C64, OPC, 32'hc, 64'h0, CNX, 8'h0);
        peer_go(8'h0c, 32'h2000);
        run_case(C64, OPC, 32'hc, 64'h0, DSP, 8'h0);
        peer_go(8'h07, 32'h1000);
        run_case(C64, OPC, 32'h7, 64'h0, CER, `EG_LOCKFAIL_CODE);
        peer_go(8'h07, 32'h2000);
        run_case(C64, OPC, 32'h7, 64'h0, DSP, 8'h0);
        peer_go(8'h0c, 32'h1000);
        run_case(C64, OPC, 32'h3, 64'h0, DSP, 8'h0);
        run_case(C64 | 32'h8, OPC, 32'hc, 64'h0, UD, 8'h0);
        @(posedge clk);
        prun <= 1'b0;
    endtask

    // main sequence
    initial
    begin
        rstn = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 6'h00;
        wdata = 32'h0;
        prun = 1'b0;
        pleaf = 8'h00;
        ppage = 32'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        test_regs();
        test_faults();
        test_exit();
        test_addr();
        test_conc();
        final_report();
    end
endmodule // test_privileged_enclave_op_gate
